/* File: verilog/qfbx_pkg.sv */
// package of constants for the queue flag bus expansion control block
// assumes a single 250 MHz system clock standing in for the write clock
package qfbx_pkg;
    localparam int ADDR_W      = 8;
    localparam int DEV_W       = 3;
    localparam int QUEUE_W     = 5;
    localparam int QUAD_W      = 2;
    localparam int FLAG_W      = 8;
    localparam int NUM_QUEUES  = 32;
    localparam int NUM_QUADS   = 4;
    localparam logic [QUAD_W-1:0] QUAD_FIRST = 2'h0;
    localparam logic [QUAD_W-1:0] QUAD_LAST  = 2'h3;
    localparam logic [DEV_W-1:0]  DEV_CODE_RST = 3'h0;
    localparam logic [FLAG_W-1:0] FLAG_IDLE    = 8'hff;
    // width codes: 0 = x36, 1 = x18, 2 = x9
    localparam logic [1:0] WIDTH_X36 = 2'h0;
    localparam logic [1:0] WIDTH_X18 = 2'h1;
    localparam logic [1:0] WIDTH_X9  = 2'h2;
    localparam int PIN_SYNC_STAGES = 3;
    typedef enum logic [1:0] {
        QFBX_POLL_IDLE,
        QFBX_POLL_RUN
    } qfbx_poll_t;
endpackage

/* File: verilog/qfbx_pin_sync.sv */
// pin synchroniser: three flops, change accepted when stages two and three agree
// assumes async pins arriving into the clk_sys domain
`timescale 1ns/100ps
`default_nettype none
module qfbx_pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_sys,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] pinOut
);
    import qfbx_pkg::*;
    logic [WIDTH-1:0] s1_r, s2_r, s3_r, out_r;
    logic [WIDTH-1:0] out_nxt;
    always_comb begin
        out_nxt = out_r;
        for (int i = 0; i < WIDTH; i++) begin
            if (s2_r[i] == s3_r[i]) begin
                out_nxt[i] = s3_r[i];
            end
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            s1_r  <= '0;
            s2_r  <= '0;
            s3_r  <= '0;
            out_r <= '0;
        end else begin
            s1_r  <= pinIn;
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            out_r <= out_nxt;
        end
    end
    assign pinOut = out_r;
endmodule
`default_nettype wire

/* File: verilog/qfbx_ctrl.sv */
// flag bus, token chain, device decode and output ownership control
// assumes write/read host logic on clk_sys and chained peers on pins
// Summary of operation
// - direct mode: strobe high loads addressed quadrant onto almost-full flag bus
// - polled mode: each edge loads next quadrant, first to fourth, then releases the bus and waits for the token
// - sync output high while own first quadrant is on the bus
// - token output pulses when the last quadrant is placed on the bus
// - token received: load first quadrant on the following edge
// - address buses are 8 bits: 3 device bits, 5 queue bits
// - act on a selection only when top address bits match device code
// - device code captured at master reset; host keeps inputs stable
// - width selects and bus matching give x9/x18/x36, one port x36
// - master select sampled at reset: high master, low slave
// - after reset master owns shared outputs, slaves release them
// - master reset is a low pulse; programming needed before operation
// - master: output enable low drives data bus, high releases it
// - slave: data bus released until selected on the read port
// - flag mode sampled at reset: high polled, low direct
`timescale 1ns/100ps
`default_nettype none
module qfbx_ctrl
    import qfbx_pkg::*;
(
    input  wire logic                          clk_sys,
    input  wire logic                          rstn,
    input  wire logic                          masterResetN,
    input  wire logic                          serialProgrammingDone,
    input  wire logic                          flagModeSelect,
    input  wire logic                          masterSelect,
    input  wire logic [qfbx_pkg::DEV_W-1:0]    deviceSelectCode,
    input  wire logic                          inputWidthSelect,
    input  wire logic                          outputWidthSelect,
    input  wire logic                          busMatchingSelect,
    input  wire logic                          almostFullBusStrobe,
    input  wire logic [qfbx_pkg::ADDR_W-1:0]   writeQueueAddress,
    input  wire logic                          writeAddrEnable,
    input  wire logic [qfbx_pkg::ADDR_W-1:0]   readQueueAddress,
    input  wire logic                          readAddrEnable,
    input  wire logic [qfbx_pkg::NUM_QUEUES-1:0] queueAlmostFullN,
    input  wire logic                          almostFullTokenIn,
    input  wire logic                          outputEnableN,
    output logic      [qfbx_pkg::FLAG_W-1:0]   almostFullFlagBus,
    output logic                               almostFullFlagBusOeN,
    output logic                               almostFullBusSync,
    output logic                               almostFullTokenOut,
    output logic                               dataOutOeN,
    output logic                               sharedOutOeN,
    output logic                               isMaster,
    output logic                               polledMode,
    output logic                               programmed,
    output logic      [1:0]                    inputWidth,
    output logic      [1:0]                    outputWidth,
    output logic                               writeSelMatch,
    output logic      [qfbx_pkg::QUEUE_W-1:0]  writeQueueSel,
    output logic                               readSelMatch,
    output logic      [qfbx_pkg::QUEUE_W-1:0]  readQueueSel
);

    // ************************************************
    // pin synchronisers
    // ************************************************
    // output enable is async by nature; three flops plus the output flop cost 4 cycles of latency
    logic [2:0] pinSync;
    qfbx_pin_sync #(.WIDTH(3)) uPinSync (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .pinIn   ({masterResetN, almostFullTokenIn, outputEnableN}),
        .pinOut  (pinSync)
    );
    logic mrsN, tokenIn, oeN;
    assign mrsN    = pinSync[2];
    assign tokenIn = pinSync[1];
    assign oeN     = pinSync[0];

    // ************************************************
    // master reset capture of straps
    // ************************************************
    logic             mrsN_r, mrsN_nxt;
    logic             polled_r, polled_nxt;
    logic             master_r, master_nxt;
    logic [DEV_W-1:0] devCode_r, devCode_nxt;
    logic [1:0]       inW_r, inW_nxt, outW_r, outW_nxt;
    logic             prog_r, prog_nxt;
    logic             progRise;
    assign progRise = prog_nxt && !prog_r;

    always_comb begin
        mrsN_nxt    = mrsN;
        polled_nxt  = polled_r;
        master_nxt  = master_r;
        devCode_nxt = devCode_r;
        inW_nxt     = inW_r;
        outW_nxt    = outW_r;
        prog_nxt    = prog_r;
        if (!mrsN) begin
            polled_nxt  = flagModeSelect;
            master_nxt  = masterSelect;
            devCode_nxt = deviceSelectCode;
            prog_nxt    = 1'b0;
            // with bus matching set, the width selects pick which port narrows; the other stays x36
            inW_nxt  = WIDTH_X36;
            outW_nxt = WIDTH_X36;
            if (busMatchingSelect) begin
                if (inputWidthSelect && !outputWidthSelect) begin
                    inW_nxt = WIDTH_X18;
                end else if (inputWidthSelect && outputWidthSelect) begin
                    inW_nxt = WIDTH_X9;
                end else if (!inputWidthSelect && outputWidthSelect) begin
                    outW_nxt = WIDTH_X18;
                end else begin
                    outW_nxt = WIDTH_X9;
                end
            end
        end else if (mrsN_r && !serialProgrammingDone) begin
            prog_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            mrsN_r    <= 1'b0;
            polled_r  <= 1'b0;
            master_r  <= 1'b0;
            devCode_r <= DEV_CODE_RST;
            inW_r     <= WIDTH_X36;
            outW_r    <= WIDTH_X36;
            prog_r    <= 1'b0;
        end else begin
            mrsN_r    <= mrsN_nxt;
            polled_r  <= polled_nxt;
            master_r  <= master_nxt;
            devCode_r <= devCode_nxt;
            inW_r     <= inW_nxt;
            outW_r    <= outW_nxt;
            prog_r    <= prog_nxt;
        end
    end

    // ************************************************
    // queue selection decode
    // ************************************************
    logic               wrMatch_r, wrMatch_nxt, rdMatch_r, rdMatch_nxt;
    logic [QUEUE_W-1:0] wrQ_r, wrQ_nxt, rdQ_r, rdQ_nxt;
    logic               rdOwned_r, rdOwned_nxt;

    always_comb begin
        wrMatch_nxt = wrMatch_r;
        wrQ_nxt     = wrQ_r;
        rdMatch_nxt = rdMatch_r;
        rdQ_nxt     = rdQ_r;
        rdOwned_nxt = rdOwned_r;
        if (writeAddrEnable && prog_r) begin
            wrMatch_nxt = writeQueueAddress[ADDR_W-1 -: DEV_W] == devCode_r;
            if (wrMatch_nxt) begin
                wrQ_nxt = writeQueueAddress[QUEUE_W-1:0];
            end
        end
        if (readAddrEnable && prog_r) begin
            rdMatch_nxt = readQueueAddress[ADDR_W-1 -: DEV_W] == devCode_r;
            rdOwned_nxt = rdMatch_nxt;
            if (rdMatch_nxt) begin
                rdQ_nxt = readQueueAddress[QUEUE_W-1:0];
            end
        end
        if (!mrsN) begin
            wrMatch_nxt = 1'b0;
            rdMatch_nxt = 1'b0;
            rdOwned_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            wrMatch_r <= 1'b0;
            wrQ_r     <= '0;
            rdMatch_r <= 1'b0;
            rdQ_r     <= '0;
            rdOwned_r <= 1'b0;
        end else begin
            wrMatch_r <= wrMatch_nxt;
            wrQ_r     <= wrQ_nxt;
            rdMatch_r <= rdMatch_nxt;
            rdQ_r     <= rdQ_nxt;
            rdOwned_r <= rdOwned_nxt;
        end
    end

    // ************************************************
    // almost-full flag bus: direct and polled
    // ************************************************
    qfbx_poll_t         poll_r, poll_nxt;
    logic [QUAD_W-1:0]  quad_r, quad_nxt;
    logic               busOwn_r, busOwn_nxt;
    logic               sync_r, sync_nxt, tok_r, tok_nxt;
    logic [FLAG_W-1:0]  flags_r, flags_nxt;
    logic               tokenEdge, tokenIn_r;
    assign tokenEdge = tokenIn && !tokenIn_r;

    always_comb begin
        poll_nxt   = poll_r;
        quad_nxt   = quad_r;
        busOwn_nxt = busOwn_r;
        sync_nxt   = 1'b0;
        tok_nxt    = 1'b0;
        flags_nxt  = flags_r;
        if (!polled_r) begin
            // direct: no device match means another device owns the bus
            if (almostFullBusStrobe && prog_r) begin
                busOwn_nxt = writeQueueAddress[ADDR_W-1 -: DEV_W] == devCode_r;
                quad_nxt   = writeQueueAddress[QUEUE_W-1 -: QUAD_W];
            end
            flags_nxt = queueAlmostFullN[quad_r*FLAG_W +: FLAG_W];
        end else begin
            unique case (poll_r)
                QFBX_POLL_IDLE: begin
                    busOwn_nxt = 1'b0;
                    // master starts the ring once programmed; others wait for the token
                    if ((prog_r && tokenEdge) || (master_r && progRise)) begin
                        poll_nxt   = QFBX_POLL_RUN;
                        quad_nxt   = QUAD_FIRST;
                        busOwn_nxt = 1'b1;
                        sync_nxt   = 1'b1;
                        flags_nxt  = queueAlmostFullN[0 +: FLAG_W];
                    end
                end
                QFBX_POLL_RUN: begin
                    if (quad_r == QUAD_LAST) begin
                        poll_nxt   = QFBX_POLL_IDLE;
                        busOwn_nxt = 1'b0;
                        flags_nxt  = FLAG_IDLE;
                    end else begin
                        quad_nxt  = quad_r + 2'h1;
                        tok_nxt   = quad_nxt == QUAD_LAST;
                        flags_nxt = queueAlmostFullN[quad_nxt*FLAG_W +: FLAG_W];
                    end
                end
            endcase
        end
        if (!mrsN) begin
            poll_nxt   = QFBX_POLL_IDLE;
            busOwn_nxt = 1'b0;
            flags_nxt  = FLAG_IDLE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            poll_r    <= QFBX_POLL_IDLE;
            quad_r    <= QUAD_FIRST;
            busOwn_r  <= 1'b0;
            sync_r    <= 1'b0;
            tok_r     <= 1'b0;
            flags_r   <= FLAG_IDLE;
            tokenIn_r <= 1'b0;
        end else begin
            poll_r    <= poll_nxt;
            quad_r    <= quad_nxt;
            busOwn_r  <= busOwn_nxt;
            sync_r    <= sync_nxt;
            tok_r     <= tok_nxt;
            flags_r   <= flags_nxt;
            tokenIn_r <= tokenIn;
        end
    end

    // ************************************************
    // outputs and ownership (enables active low)
    // ************************************************
    assign almostFullFlagBus    = flags_r;
    assign almostFullFlagBusOeN = !(busOwn_r || (master_r && !polled_r && !prog_r));
    assign almostFullBusSync    = sync_r;
    assign almostFullTokenOut   = tok_r;
    assign sharedOutOeN         = !(master_r && mrsN_r);
    assign dataOutOeN           = !((master_r || rdOwned_r) && !oeN);
    assign isMaster             = master_r;
    assign polledMode           = polled_r;
    assign programmed           = prog_r;
    assign inputWidth           = inW_r;
    assign outputWidth          = outW_r;
    assign writeSelMatch        = wrMatch_r;
    assign writeQueueSel        = wrQ_r;
    assign readSelMatch         = rdMatch_r;
    assign readQueueSel         = rdQ_r;

    // ************************************************
    // assertions
    // ************************************************
    AST_POLL_ORDER: assert property (@(posedge clk_sys) disable iff (!rstn)
        (polled_r && poll_r == QFBX_POLL_RUN && quad_r != QUAD_LAST)
        |=> quad_r == $past(quad_r) + 2'h1)
        else $error("polled quadrant did not advance by one");
    AST_SYNC_Q1: assert property (@(posedge clk_sys) disable iff (!rstn)
        almostFullBusSync |-> (quad_r == QUAD_FIRST && busOwn_r))
        else $error("sync high outside own first quadrant");
    AST_TOKEN_LAST: assert property (@(posedge clk_sys) disable iff (!rstn)
        almostFullTokenOut |-> (quad_r == QUAD_LAST && poll_r == QFBX_POLL_RUN))
        else $error("token pulsed away from last quadrant");
    AST_TOKEN_PULSE: assert property (@(posedge clk_sys) disable iff (!rstn)
        almostFullTokenOut |=> !almostFullTokenOut)
        else $error("token wider than one cycle");
    AST_SYNC_SPACING: assert property (@(posedge clk_sys) disable iff (!rstn)
        almostFullBusSync |=> !almostFullBusSync [*3])
        else $error("sync repeated within four quadrants");
    AST_DIRECT_SEL: assert property (@(posedge clk_sys) disable iff (!rstn)
        (!polled_r && prog_r && mrsN && almostFullBusStrobe)
        |=> busOwn_r == ($past(writeQueueAddress[ADDR_W-1 -: DEV_W]) == devCode_r)
        ##1 flags_r == queueAlmostFullN[$past(quad_r)*FLAG_W +: FLAG_W])
        else $error("direct quadrant not placed on flag bus");
    AST_WR_MATCH: assert property (@(posedge clk_sys) disable iff (!rstn)
        (writeAddrEnable && prog_r && mrsN)
        |=> wrMatch_r == ($past(writeQueueAddress[ADDR_W-1 -: DEV_W]) == devCode_r))
        else $error("write device match wrong");
    AST_TOKEN_START: assert property (@(posedge clk_sys) disable iff (!rstn)
        (polled_r && poll_r == QFBX_POLL_IDLE && prog_r && tokenEdge && mrsN)
        |=> almostFullBusSync && !almostFullFlagBusOeN)
        else $error("token did not start first quadrant");
    AST_SLAVE_DATA: assert property (@(posedge clk_sys) disable iff (!rstn)
        (!master_r && !rdOwned_r) |-> dataOutOeN)
        else $error("unselected slave drives data bus");
    AST_MASTER_DATA: assert property (@(posedge clk_sys) disable iff (!rstn)
        master_r |-> dataOutOeN == oeN)
        else $error("master data enable does not follow output enable");

    COV_POLL_RING: cover property (@(posedge clk_sys) disable iff (!rstn)
        almostFullBusSync ##3 almostFullTokenOut);
    COV_DIRECT: cover property (@(posedge clk_sys) disable iff (!rstn)
        !polled_r && almostFullBusStrobe && prog_r);
    COV_SLAVE_READ: cover property (@(posedge clk_sys) disable iff (!rstn)
        !master_r && !dataOutOeN);

endmodule
`default_nettype wire

/* File: test/qfbx_peer_model.sv */
// peer device model standing on the almost-full token chain
// assumes the block's token pins and a single clk_sys domain
`timescale 1ns/100ps
`default_nettype none
module qfbx_peer_model #(
    parameter int RUN_LEN   = 4,
    parameter int PULSE_LEN = 2
) (
    input  wire logic clk_sys,
    input  wire logic rstn,
    input  wire logic chainEnable,
    input  wire logic tokenFromDut,
    output logic      tokenToDut
);
    // ************************************************
    // peer quadrant run and token return
    // ************************************************
    // a single-cycle token can be lost in the pin synchroniser's
    // agreement check, so the returned token is held PULSE_LEN cycles
    int   cnt_r;
    logic prev_r;
    always_ff @(posedge clk_sys) begin
        prev_r <= tokenFromDut;
        if (!rstn || !chainEnable) begin
            cnt_r      <= 0;
            tokenToDut <= 1'b0;
        end else if (tokenFromDut && !prev_r && cnt_r == 0) begin
            cnt_r      <= 1;
            tokenToDut <= 1'b0;
        end else if (cnt_r != 0) begin
            cnt_r      <= (cnt_r == RUN_LEN + PULSE_LEN) ? 0 : cnt_r + 1;
            tokenToDut <= (cnt_r > RUN_LEN);
        end else begin
            tokenToDut <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: test/queue_flag_bus_expansion_ctrl_tb.sv */
// self-checking bench for the flag bus, token and ownership control
// assumes the peer model closes the token loop in polled mode
`timescale 1ns/100ps
`default_nettype none
module queue_flag_bus_expansion_ctrl_tb;
    import qfbx_pkg::*;
    // ************************************************
    // signals, clock and instances
    // ************************************************
    localparam int MAX_CYCLES = 2000;
    localparam logic [NUM_QUEUES-1:0] FLAGS = 32'h7e3c_a512;
    logic              clk_sys, rstn, masterResetN, serialProgrammingDone;
    logic              flagModeSelect, masterSelect, inputWidthSelect;
    logic              outputWidthSelect, busMatchingSelect, almostFullBusStrobe;
    logic [DEV_W-1:0]  deviceSelectCode;
    logic [ADDR_W-1:0] writeQueueAddress, readQueueAddress;
    logic              writeAddrEnable, readAddrEnable, outputEnableN, chainOn;
    logic              almostFullTokenIn, almostFullTokenOut, almostFullBusSync;
    logic [FLAG_W-1:0] almostFullFlagBus;
    logic              almostFullFlagBusOeN, dataOutOeN, sharedOutOeN;
    logic              isMaster, polledMode, programmed, writeSelMatch, readSelMatch;
    logic [1:0]        inputWidth, outputWidth;
    logic [QUEUE_W-1:0] writeQueueSel, readQueueSel;
    int                num_errors = 0;
    int                num_checks = 0;
    int                cycles     = 0;

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    qfbx_ctrl qfbx_ctrl_inst (
        .clk_sys(clk_sys), .rstn(rstn), .masterResetN(masterResetN),
        .serialProgrammingDone(serialProgrammingDone), .flagModeSelect(flagModeSelect),
        .masterSelect(masterSelect), .deviceSelectCode(deviceSelectCode),
        .inputWidthSelect(inputWidthSelect), .outputWidthSelect(outputWidthSelect),
        .busMatchingSelect(busMatchingSelect), .almostFullBusStrobe(almostFullBusStrobe),
        .writeQueueAddress(writeQueueAddress), .writeAddrEnable(writeAddrEnable),
        .readQueueAddress(readQueueAddress), .readAddrEnable(readAddrEnable),
        .queueAlmostFullN(FLAGS), .almostFullTokenIn(almostFullTokenIn),
        .outputEnableN(outputEnableN), .almostFullFlagBus(almostFullFlagBus),
        .almostFullFlagBusOeN(almostFullFlagBusOeN), .almostFullBusSync(almostFullBusSync),
        .almostFullTokenOut(almostFullTokenOut), .dataOutOeN(dataOutOeN),
        .sharedOutOeN(sharedOutOeN), .isMaster(isMaster), .polledMode(polledMode),
        .programmed(programmed), .inputWidth(inputWidth), .outputWidth(outputWidth),
        .writeSelMatch(writeSelMatch), .writeQueueSel(writeQueueSel),
        .readSelMatch(readSelMatch), .readQueueSel(readQueueSel)
    );

    qfbx_peer_model qfbx_peer_model_inst (
        .clk_sys(clk_sys), .rstn(rstn), .chainEnable(chainOn),
        .tokenFromDut(almostFullTokenOut), .tokenToDut(almostFullTokenIn)
    );

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == MAX_CYCLES) begin
            num_errors++;
            summarize();
        end
    end

    // ************************************************
    // tasks
    // ************************************************
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    // inputs always change 1 ns after the rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic mreset(input logic fm, input logic master_select, input logic [DEV_W-1:0] code);
        int i;
        masterResetN          = 1'b0;
        serialProgrammingDone = 1'b1;
        flagModeSelect        = fm;
        masterSelect          = master_select;
        deviceSelectCode      = code;
        inputWidthSelect      = code[0];
        busMatchingSelect     = code[0];
        tick(6);
        check(programmed, 1'b0, "programmed during reset");
        masterResetN = 1'b1;
        tick(2);
        serialProgrammingDone = 1'b0;
        for (i = 0; i < 20 && programmed !== 1'b1; i++) tick(1);
        check(programmed, 1'b1, "programmed");
        check(isMaster, master_select, "master strap");
        check(polledMode, fm, "mode strap");
        check(inputWidth == WIDTH_X36 || outputWidth == WIDTH_X36, 1'b1, "x36");
        check({inputWidth, outputWidth}, {(code[0] ? WIDTH_X18 : WIDTH_X36), WIDTH_X36}, "widths");
    endtask

    // strobe is raised only once programmed has been seen
    task automatic strobe(input logic [ADDR_W-1:0] addr, input logic hit, input int q);
        almostFullBusStrobe = 1'b1;
        writeQueueAddress   = addr;
        tick(1);
        almostFullBusStrobe = 1'b0;
        tick(1);
        check(almostFullFlagBusOeN, !hit, "flag bus enable");
        tick(1);
        if (hit) check(almostFullFlagBus, FLAGS[8*q +: 8], "quadrant");
    endtask

    task automatic qsel(input logic rd, input logic [ADDR_W-1:0] addr, input logic hit,
                        input logic [QUEUE_W-1:0] qexp);
        writeQueueAddress = addr;
        readQueueAddress  = addr;
        writeAddrEnable   = !rd;
        readAddrEnable    = rd;
        tick(1);
        writeAddrEnable = 1'b0;
        readAddrEnable  = 1'b0;
        check(rd ? readSelMatch : writeSelMatch, hit, "select match");
        check(rd ? readQueueSel : writeQueueSel, qexp, "selected queue");
        tick(1);
    endtask

    task automatic waitOe(input logic exp);
        int i;
        for (i = 0; i < 8 && dataOutOeN !== exp; i++) tick(1);
    endtask

    task automatic pollRing();
        int i;
        for (i = 0; i < 40 && almostFullBusSync !== 1'b1; i++) tick(1);
        for (i = 0; i < NUM_QUADS; i++) begin
            check(almostFullBusSync, i == 0, "sync");
            check(almostFullFlagBus, FLAGS[8*i +: 8], "polled quadrant");
            check(almostFullTokenOut, i == NUM_QUADS - 1, "token out");
            tick(1);
        end
        check(almostFullFlagBusOeN, 1'b1, "bus released");
    endtask

    // ************************************************
    // main sequence
    // ************************************************
    initial begin
        rstn                  = 1'b0;
        masterResetN          = 1'b1;
        serialProgrammingDone = 1'b1;
        {flagModeSelect, masterSelect, inputWidthSelect} = 3'h0;
        {outputWidthSelect, busMatchingSelect, almostFullBusStrobe} = 3'h0;
        deviceSelectCode  = DEV_CODE_RST;
        writeQueueAddress = 8'h00;
        readQueueAddress  = 8'h00;
        writeAddrEnable   = 1'b0;
        readAddrEnable    = 1'b0;
        outputEnableN     = 1'b1;
        chainOn           = 1'b0;
        tick(10);
        check(almostFullFlagBusOeN, 1'b1, "flag enable in reset");
        check(almostFullFlagBus, FLAG_IDLE, "flag idle in reset");
        rstn = 1'b1;
        tick(4);
        mreset(1'b0, 1'b1, 3'h2);
        check(sharedOutOeN, 1'b0, "master owns outputs");
        for (int q = 0; q < NUM_QUADS; q++) strobe({3'h2, q[1:0], 3'h5}, 1'b1, q);
        strobe({3'h6, 2'h1, 3'h0}, 1'b0, 0);
        qsel(1'b0, {3'h2, 5'h13}, 1'b1, 5'h13);
        qsel(1'b0, {3'h3, 5'h0a}, 1'b0, 5'h13);
        qsel(1'b1, {3'h2, 5'h07}, 1'b1, 5'h07);
        qsel(1'b1, {3'h7, 5'h1f}, 1'b0, 5'h07);
        outputEnableN = 1'b0;
        waitOe(1'b0);
        check(dataOutOeN, 1'b0, "master drives data");
        outputEnableN = 1'b1;
        waitOe(1'b1);
        check(dataOutOeN, 1'b1, "master releases data");
        // polled: strobe stays low, token looped through the peer
        chainOn = 1'b1;
        {writeQueueAddress, readQueueAddress} = 16'h0000;
        mreset(1'b1, 1'b1, 3'h0);
        pollRing();
        pollRing();
        chainOn = 1'b0;
        mreset(1'b0, 1'b0, 3'h5);
        outputEnableN = 1'b0;
        tick(6);
        check(dataOutOeN, 1'b1, "slave data released");
        check(sharedOutOeN, 1'b1, "slave shared released");
        qsel(1'b1, {3'h5, 5'h02}, 1'b1, 5'h02);
        waitOe(1'b0);
        check(dataOutOeN, 1'b0, "selected slave drives");
        summarize();
    end
endmodule
`default_nettype wire
